// file: pocq_blank_timer.sv
`timescale 1ns/1ns
module pocq_blank_timer (
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic                           start,
   input  wire logic [pocq_pkg::TIMER_W-1:0]   loadVal,
   output logic                                active
);

   logic [pocq_pkg::TIMER_W-1:0] cnt_r;
   logic [pocq_pkg::TIMER_W-1:0] cnt_nxt;
   logic                         loadNonZero;

   assign loadNonZero = (loadVal != '0);

   // ----------------------------------------
   // Countdown
   // ----------------------------------------
   // Start cycle already blanks, so load one less
   assign cnt_nxt = (start && loadNonZero) ? loadVal - 1'b1 :
                    (cnt_r != '0)          ? cnt_r - 1'b1   : cnt_r;

   assign active = (start && loadNonZero) || (cnt_r != '0);

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule

// file: pocq_checker.sv
`timescale 1ns/1ns
module pocq_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [15:0] regAddr,
   input wire logic [7:0]  regWrData,
   input wire logic        regWrStb,
   input wire logic        regRdStb,
   input wire logic [7:0]  regRdData,
   input wire logic        pwmOutputOne,
   input wire logic        pwmOutputTwo,
   input wire logic        ocComparator,
   input wire logic [3:0]  faultResponseSel,
   input wire logic        primaryOvercurrentFlag,
   input wire logic        faultActionReq,
   input wire logic [3:0]  faultActionSel
);
   // ----------------------------------------
   // Shadow settings and pin history
   // ----------------------------------------
   localparam int BLK [8] = '{0, 2, 4, 6, 10, 20, 30, 40};
   logic [7:0] settings_r;
   logic       one_r;
   logic       two_r;
   logic [5:0] age_r;
   logic [5:0] run_r;
   wire        flg      = primaryOvercurrentFlag;
   wire        oneRise  = pwmOutputOne & ~one_r;
   wire  [5:0] ageNow   = (oneRise | (pwmOutputTwo & ~two_r)) ? 6'h00 : age_r;
   wire  [5:0] blankNow = 6'(BLK[settings_r[6:4]]);
   always_ff @(posedge clk) begin
      if (rst) begin
         settings_r <= 8'h00;
         one_r      <= 1'b0;
         two_r      <= 1'b0;
         age_r      <= 6'h3f;
         run_r      <= 6'h00;
      end else begin
         if (regWrStb && regAddr == pocq_pkg::SETTINGS_ADDR)
            settings_r <= regWrData;
         one_r <= pwmOutputOne;
         two_r <= pwmOutputTwo;
         // Saturate so quiet spells never wrap
         age_r <= (ageNow == 6'h3f) ? ageNow : ageNow + 6'h01;
         run_r <= !ocComparator ? 6'h00 : (run_r == 6'h3f) ? run_r : run_r + 6'h01;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_IGNORE: assert property (settings_r[7] |-> !flg)
      else $error("flag high while ignore bit set");
   AST_RDIDLE: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
      else $error("read data not zero outside read");
   AST_RDSET: assert property ($past(regRdStb && regAddr == pocq_pkg::SETTINGS_ADDR)
      |-> regRdData == $past(settings_r)) else $error("settings read back wrong");
   AST_REQ: assert property ($rose(flg) && !$past(settings_r[7])
      |=> faultActionReq && faultActionSel == $past(faultResponseSel)) else $error("no fault action");
   AST_REQONE: assert property (faultActionReq |-> $past(flg) && !$past(flg, 2))
      else $error("fault action without flag rise");
   AST_DEB: assert property ($rose(flg) && !$past(settings_r[7])
      |-> run_r > {$past(settings_r[1:0]), 1'b0}) else $error("flag before debounce");
   AST_BLANK: assert property ($rose(flg) && !$past(settings_r[7])
      |-> $past(ageNow) >= $past(blankNow)) else $error("flag from blanked comparator");
   AST_CLR: assert property ($fell(flg) |-> settings_r[7] || $past(oneRise)
      || $past(oneRise, 2) || $past(regWrStb)) else $error("flag dropped mid cycle");
endmodule

bind pocq_qualifier pocq_checker chk (.clk, .rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
   .pwmOutputOne, .pwmOutputTwo, .ocComparator, .faultResponseSel, .primaryOvercurrentFlag,
   .faultActionReq, .faultActionSel);

// file: pocq_pkg.sv
package pocq_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [15:0] SETTINGS_ADDR  = 16'hFE6F;
   localparam logic [15:0] STATUS_ADDR    = 16'hFE7F;
   localparam logic [7:0]  SETTINGS_RESET = 8'h00;
   localparam int          IGNORE_BIT     = 7;
   localparam int          BLANK_HI       = 6;
   localparam int          BLANK_LO       = 4;
   localparam int          CYCLES_HI      = 3;
   localparam int          CYCLES_LO      = 2;
   localparam int          DEBOUNCE_HI    = 1;
   localparam int          DEBOUNCE_LO    = 0;
   localparam int          STAT_FLAG_BIT  = 0;
   localparam int          STAT_BLANK_BIT = 1;
   localparam int          STAT_QUAL_BIT  = 2;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int BLANK_NS [8]  = '{0, 40, 80, 120, 200, 400, 600, 800};
   localparam int DEB_NS   [4]  = '{0, 40, 80, 120};
   localparam int CYC_TGT  [4]  = '{1, 8, 64, 512};
   localparam int TIMER_W       = 6;
   localparam int CYC_W         = 11;

   // Least times: round up to whole clocks
   function automatic int nsToCycles(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   function automatic logic [TIMER_W-1:0] blankCycles(input logic [2:0] sel);
      return TIMER_W'(nsToCycles(BLANK_NS[sel]));
   endfunction

   function automatic logic [TIMER_W-1:0] debounceCycles(input logic [1:0] sel);
      return TIMER_W'(nsToCycles(DEB_NS[sel]));
   endfunction

   function automatic logic [CYC_W-1:0] cycleTarget(input logic [1:0] sel);
      return CYC_W'(CYC_TGT[sel]);
   endfunction

   // ----------------------------------------
   // Qualifier states, Gray along the path
   // ----------------------------------------
   typedef enum logic [1:0] {
      QS_IDLE  = 2'b00,
      QS_COUNT = 2'b01,
      QS_FLAG  = 2'b11
   } pocq_state_t;

endpackage

// file: pocq_pwm_model.sv
`timescale 1ns/1ns
module pocq_pwm_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ocLevel,
   input  wire logic [7:0] ocSpan,
   output logic            pwmOne,
   output logic            pwmTwo,
   output logic            ocOut
);
   // ----------------------------------------
   // Two outputs, period 100 clocks
   // ----------------------------------------
   logic [7:0] phase_r;
   always_ff @(posedge clk) begin
      if (rst || phase_r == 8'h63)
         phase_r <= 8'h00;
      else
         phase_r <= phase_r + 8'h01;
   end
   assign pwmOne = phase_r < 8'h28;
   assign pwmTwo = phase_r >= 8'h32 && phase_r < 8'h5a;
   // Spike for ocSpan clocks from output one switch-on, like a real sense
   assign ocOut  = ocLevel && phase_r < ocSpan;
endmodule

// file: pocq_qualifier.sv
`timescale 1ns/1ns
module pocq_qualifier (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] regAddr,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regWrStb,
   input  wire logic        regRdStb,
   output logic      [7:0]  regRdData,
   input  wire logic        pwmOutputOne,
   input  wire logic        pwmOutputTwo,
   input  wire logic        ocComparator,
   input  wire logic [3:0]  faultResponseSel,
   output logic             primaryOvercurrentFlag,
   output logic             faultActionReq,
   output logic      [3:0]  faultActionSel
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0]                   settings_r;
   logic [7:0]                   rdData_r;
   logic                         pwmOnePrev_r;
   logic                         pwmTwoPrev_r;
   logic [pocq_pkg::TIMER_W-1:0] debCnt_r;
   logic [pocq_pkg::TIMER_W-1:0] debCnt_nxt;
   logic [pocq_pkg::CYC_W-1:0]   cycCnt_r;
   logic [pocq_pkg::CYC_W-1:0]   cycCnt_nxt;
   logic                         cycTrig_r;
   logic                         cycTrig_nxt;
   logic                         flagPrev_r;
   logic [3:0]                   actSel_r;
   pocq_pkg::pocq_state_t        state_r;
   pocq_pkg::pocq_state_t        state_nxt;

   wire        wrSettings;
   wire        rdSettings;
   wire        rdStatus;
   wire [7:0]  rdMux;
   wire [7:0]  statusWord;
   wire        ignoreOc;
   wire [2:0]  blankSel;
   wire [1:0]  cycSel;
   wire [1:0]  debSel;
   wire        pwmOneRise;
   wire        pwmTwoRise;
   wire        blankStart;
   wire        blanking;
   wire        compQual;
   wire        debounced;
   wire        trigHit;
   wire        targetMet;
   wire        boundMet;
   wire [pocq_pkg::TIMER_W-1:0] blankLoad;
   wire [pocq_pkg::TIMER_W-1:0] debNeed;
   wire [pocq_pkg::CYC_W-1:0]   cycNeed;
   wire [pocq_pkg::CYC_W-1:0]   cycInc;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   assign wrSettings = regWrStb && (regAddr == pocq_pkg::SETTINGS_ADDR);
   assign rdSettings = regRdStb && (regAddr == pocq_pkg::SETTINGS_ADDR);
   assign rdStatus   = regRdStb && (regAddr == pocq_pkg::STATUS_ADDR);

   assign statusWord = {5'h0,
                        compQual,
                        blanking,
                        primaryOvercurrentFlag};

   // Unmapped reads and idle cycles return zero
   assign rdMux = rdSettings ? settings_r :
                  rdStatus   ? statusWord : 8'h00;

   assign regRdData = rdData_r;

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   assign ignoreOc = settings_r[pocq_pkg::IGNORE_BIT];
   assign blankSel = settings_r[pocq_pkg::BLANK_HI:pocq_pkg::BLANK_LO];
   assign cycSel   = settings_r[pocq_pkg::CYCLES_HI:pocq_pkg::CYCLES_LO];
   assign debSel   = settings_r[pocq_pkg::DEBOUNCE_HI:pocq_pkg::DEBOUNCE_LO];

   assign blankLoad = pocq_pkg::blankCycles(blankSel);
   assign debNeed   = pocq_pkg::debounceCycles(debSel);
   assign cycNeed   = pocq_pkg::cycleTarget(cycSel);

   // ----------------------------------------
   // Leading edge blanking
   // ----------------------------------------
   assign pwmOneRise = pwmOutputOne && !pwmOnePrev_r;
   assign pwmTwoRise = pwmOutputTwo && !pwmTwoPrev_r;
   assign blankStart = pwmOneRise || pwmTwoRise;

   pocq_blank_timer u_blank (
      .clk     (clk),
      .rst     (rst),
      .start   (blankStart),
      .loadVal (blankLoad),
      .active  (blanking)
   );

   assign compQual = ocComparator && !blanking && !ignoreOc;

   // ----------------------------------------
   // Debounce
   // ----------------------------------------
   // restart on drop
   assign debCnt_nxt = !compQual                  ? '0 :
                       (debCnt_r == {pocq_pkg::TIMER_W{1'b1}}) ? debCnt_r :
                       debCnt_r + 1'b1;

   // Counts clocks already high, so a set time is a true minimum
   // continuous high time
   assign debounced = compQual && (debCnt_r >= debNeed);

   // ----------------------------------------
   // Switching cycle qualification
   // ----------------------------------------
   // A switching cycle runs from one rising edge of output one to the next
   assign trigHit   = debounced && !cycTrig_r;
   assign cycInc    = (cycCnt_r == {pocq_pkg::CYC_W{1'b1}}) ? cycCnt_r : cycCnt_r + 1'b1;
   assign targetMet = (cycInc >= cycNeed);
   // Boundary trigger opens a new cycle, so it counts one past cycInc
   assign boundMet  = (cycInc >= cycNeed - 1'b1);

   always_comb begin
      cycCnt_nxt  = cycCnt_r;
      cycTrig_nxt = cycTrig_r || debounced;
      state_nxt   = state_r;
      if (pwmOneRise) begin
         if (cycTrig_r) begin
            cycCnt_nxt = cycInc;
         end else begin
            cycCnt_nxt = '0;
            state_nxt  = pocq_pkg::QS_IDLE;
         end
         cycTrig_nxt = debounced;
      end
      if (debounced && (pwmOneRise || trigHit)) begin
         if (pwmOneRise && !cycTrig_r) begin
            state_nxt = (cycNeed == pocq_pkg::CYC_W'(1)) ? pocq_pkg::QS_FLAG : pocq_pkg::QS_COUNT;
         end else if (!pwmOneRise && targetMet) begin
            state_nxt = pocq_pkg::QS_FLAG;
         end else if (pwmOneRise && boundMet) begin
            state_nxt = pocq_pkg::QS_FLAG;
         end else if (state_r == pocq_pkg::QS_IDLE) begin
            state_nxt = pocq_pkg::QS_COUNT;
         end
      end
      if (ignoreOc) begin
         cycCnt_nxt  = '0;
         cycTrig_nxt = 1'b0;
         state_nxt   = pocq_pkg::QS_IDLE;
      end
   end

   assign primaryOvercurrentFlag = (state_r == pocq_pkg::QS_FLAG) && !ignoreOc;

   // ----------------------------------------
   // Fault action hand-off
   // ----------------------------------------
   // external action select
   assign faultActionSel = actSel_r;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         settings_r <= pocq_pkg::SETTINGS_RESET;
         rdData_r   <= 8'h00;
      end else begin
         if (wrSettings) begin
            settings_r <= regWrData;
         end
         rdData_r <= rdMux;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pwmOnePrev_r <= 1'b0;
         pwmTwoPrev_r <= 1'b0;
         debCnt_r     <= '0;
      end else begin
         pwmOnePrev_r <= pwmOutputOne;
         pwmTwoPrev_r <= pwmOutputTwo;
         debCnt_r     <= debCnt_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cycCnt_r  <= '0;
         cycTrig_r <= 1'b0;
         state_r   <= pocq_pkg::QS_IDLE;
      end else begin
         cycCnt_r  <= cycCnt_nxt;
         cycTrig_r <= cycTrig_nxt;
         state_r   <= state_nxt;
      end
   end

   // Selection frozen at the flag edge so the action stays coherent
   always_ff @(posedge clk) begin
      if (rst) begin
         flagPrev_r     <= 1'b0;
         faultActionReq <= 1'b0;
         actSel_r       <= 4'h0;
      end else begin
         flagPrev_r     <= primaryOvercurrentFlag;
         faultActionReq <= primaryOvercurrentFlag && !flagPrev_r;
         if (primaryOvercurrentFlag && !flagPrev_r) begin
            actSel_r <= faultResponseSel;
         end
      end
   end

endmodule

// file: pocq_qualifier_bench.sv
`timescale 1ns/1ns
module pocq_qualifier_bench;
   logic        clk, rst, regWrStb, regRdStb, pwmOne, pwmTwo, ocRaw, flag, actReq, ocLevel;
   logic [15:0] regAddr;
   logic [7:0]  regWrData, regRdData, ocSpan;
   logic [3:0]  faultResponseSel, actSel;
   int          fails, checksDone;
   int          debClk [4] = '{0, 2, 4, 6};
   int          blankClk [8] = '{0, 2, 4, 6, 10, 20, 30, 40};
   pocq_pwm_model far (.clk(clk), .rst(rst), .ocLevel(ocLevel), .ocSpan(ocSpan),
      .pwmOne(pwmOne), .pwmTwo(pwmTwo), .ocOut(ocRaw));
   pocq_qualifier uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .pwmOutputOne(pwmOne),
      .pwmOutputTwo(pwmTwo), .ocComparator(ocRaw), .faultResponseSel(faultResponseSel),
      .primaryOvercurrentFlag(flag), .faultActionReq(actReq), .faultActionSel(actSel));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checksDone++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge clk);
      regWrStb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge clk);
      regRdStb <= 1'b0;
      #1 check("regRdData", regRdData, e);
      @(posedge clk);
   endtask
   task automatic flagIs(input logic e);
      #1 check("flag", {7'h00, flag}, {7'h00, e});
      @(posedge clk);
   endtask
   task automatic setup(input logic [7:0] s, input logic [7:0] span);
      ocLevel <= 1'b0;
      ocSpan <= span;
      wr(pocq_pkg::SETTINGS_ADDR, s);
      repeat (220) @(posedge clk);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic sRegs();
      rd(pocq_pkg::SETTINGS_ADDR, pocq_pkg::SETTINGS_RESET);
      wr(pocq_pkg::SETTINGS_ADDR, 8'ha5);
      wr(16'h0000, 8'h5a);
      rd(16'h0000, 8'h00);
      rd(pocq_pkg::SETTINGS_ADDR, 8'ha5);
   endtask
   task automatic sBasic();
      setup(8'h00, 8'hff);
      faultResponseSel <= 4'h9;
      ocLevel <= 1'b1;
      @(posedge clk);
      flagIs(1'b1);
      #1 check("actReq", {7'h00, actReq}, 8'h01);
      check("actSel", {4'h0, actSel}, 8'h09);
      @(posedge clk);
      // Status: flag set, no blanking, comparator qualified
      rd(pocq_pkg::STATUS_ADDR, 8'h05);
      wr(pocq_pkg::SETTINGS_ADDR, 8'h80);
      flagIs(1'b0);
      repeat (150) @(posedge clk);
      flagIs(1'b0);
   endtask
   task automatic sDebounce();
      for (int s = 0; s < 4; s++) begin
         setup(8'(s), 8'hff);
         if (debClk[s] > 0) begin
            ocLevel <= 1'b1;
            repeat (debClk[s]) @(posedge clk);
            ocLevel <= 1'b0;
            repeat (10) @(posedge clk);
            flagIs(1'b0);
         end
         ocLevel <= 1'b1;
         repeat (debClk[s] + 1) @(posedge clk);
         flagIs(1'b1);
      end
   endtask
   task automatic sBlank();
      for (int b = 0; b < 8; b++) begin
         setup({1'b0, 3'(b), 4'h0}, 8'(blankClk[b]));
         ocLevel <= 1'b1;
         repeat (300) @(posedge clk);
         flagIs(1'b0);
         ocSpan <= 8'(blankClk[b] + 1);
         repeat (110) @(posedge clk);
         flagIs(1'b1);
      end
   endtask
   task automatic sCount();
      setup(8'h04, 8'h0a);
      // Align to mid cycle: model phase tracks edges since reset
      repeat ((163 - (($time + 10) / 20) % 100) % 100) @(posedge clk);
      ocLevel <= 1'b1;
      repeat (740) @(posedge clk);
      flagIs(1'b0);
      repeat (20) @(posedge clk);
      flagIs(1'b1);
      ocLevel <= 1'b0;
      repeat (210) @(posedge clk);
      flagIs(1'b0);
   endtask
   task automatic printVerdict();
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      regAddr = 16'h0000;
      regWrData = 8'h00;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
      faultResponseSel = 4'h0;
      ocLevel = 1'b0;
      ocSpan = 8'h00;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      sRegs();
      sBasic();
      sDebounce();
      sBlank();
      sCount();
      printVerdict();
   end
endmodule
